// ---- rtl/cpsr_regs.sv ----
// Purpose: stack pointer, data pointer pair and program status word
// Assumes: datapath requests are single-cycle pulses on clk_i
// Notes: datapath updates win over a bus write in the same cycle
//
// Summary of operation
// - push or call: increment pointer, then write
// - stack pointer resets to 07H
// - low and high bytes form 16-bit pointer
// - add/subtract carry from msb carry or borrow
// - multiply and divide clear carry
// - decimal adjust sets carry above 99
// - compare-jump carry when first less than second
// - half carry from bit 3 carry or borrow
// - status bit 5 is free software flag
// - status bits 4:3 select register bank
// - add overflow from bit 6/7 carry mismatch
// - multiply overflow when product above 255
// - parity bit shows accumulator odd parity
`timescale 1ns/1ps
`default_nettype none
module cpsr_regs
  import cpsr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [CPSR_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // stack operations
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [7:0] push_data_i,
  output logic stack_wr_o,
  output logic [7:0] stack_wr_addr_o,
  output logic [7:0] stack_wr_data_o,
  output logic [7:0] pop_addr_o,
  // data pointer
  input wire logic data_pointer_pair_load_i,
  input wire logic [15:0] data_pointer_pair_load_val_i,
  input wire logic data_pointer_pair_inc_i,
  output logic [15:0] data_pointer_pair_o,
  // flag operations
  input wire cpsr_op_t flag_op_i,
  input wire logic [7:0] opa_i,
  input wire logic [7:0] opb_i,
  input wire logic [15:0] product_i,
  input wire logic divisor_zero_i,
  input wire logic carry_set_i,
  input wire logic [7:0] accumulator_i,
  // working register addressing
  input wire logic [2:0] work_reg_i,
  output logic [7:0] work_reg_addr_o,
  output logic [1:0] bank_select_o,
  output logic [7:0] program_status_word_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] stack_top_pointer;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic carry_flag;
    logic half_carry_flag;
    logic user_flag_zero;
    logic bank_select_high;
    logic bank_select_low;
    logic signed_wrap_flag;
    logic user_flag_one;
    logic stack_wr;
    logic [7:0] stack_wr_addr;
    logic [7:0] stack_wr_data;
    logic [31:0] rdata;
  } cpsr_state_t;

  cpsr_state_t st_r;
  cpsr_state_t st_nxt;

  logic bus_wr;
  logic bus_rd;
  logic fu_update;
  cpsr_flags_t fu_flags;
  logic [7:0] idx;
  logic [7:0] psw_now;
  logic [15:0] data_pointer_pair_next;
  logic [7:0] wdat;
  logic parity;

  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] r);
    bank_addr = {3'b000, bank, r};
  endfunction

  // ****************************************
  // bus handshake
  // ****************************************
  cpsr_wb_slave u_wbs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(wb_cyc_i),
    .stb_i(wb_stb_i),
    .we_i(wb_we_i),
    .sel0_i(wb_sel_i[0]),
    .wr_o(bus_wr),
    .rd_o(bus_rd),
    .ack_o(wb_ack_o)
  );

  // ****************************************
  // flag arithmetic
  // ****************************************
  cpsr_flag_unit u_flags (
    .op_i(flag_op_i),
    .opa_i(opa_i),
    .opb_i(opb_i),
    .carry_in_i((flag_op_i == CPSR_OP_SET_CARRY) ? carry_set_i : st_r.carry_flag),
    .half_in_i(st_r.half_carry_flag),
    .wrap_in_i(st_r.signed_wrap_flag),
    .product_i(product_i),
    .divisor_zero_i(divisor_zero_i),
    .update_o(fu_update),
    .flags_o(fu_flags)
  );

  assign parity = ^accumulator_i;
  assign idx = wb_adr_i[CPSR_ADDR_W-1:2];
  assign wdat = wb_dat_i[7:0];
  assign psw_now = {st_r.carry_flag, st_r.half_carry_flag, st_r.user_flag_zero, st_r.bank_select_high,
                    st_r.bank_select_low, st_r.signed_wrap_flag, st_r.user_flag_one, parity};
  assign data_pointer_pair_next = {st_r.data_pointer_high, st_r.data_pointer_low} + 16'h0001;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.stack_wr = 1'b0;
    if (bus_wr) begin
      case (idx)
        CPSR_IDX_STACK_TOP_POINTER: begin
          st_nxt.stack_top_pointer = wdat;
        end
        CPSR_IDX_DATA_POINTER_LOW: begin
          st_nxt.data_pointer_low = wdat;
        end
        CPSR_IDX_DATA_POINTER_HIGH: begin
          st_nxt.data_pointer_high = wdat;
        end
        CPSR_IDX_PROGRAM_STATUS_WORD: begin
          // parity is read-only, bit 0 of the write is dropped
          st_nxt.carry_flag = wdat[CPSR_BIT_CARRY];
          st_nxt.half_carry_flag = wdat[CPSR_BIT_HALF_CARRY];
          st_nxt.user_flag_zero = wdat[CPSR_BIT_USER_ZERO];
          st_nxt.bank_select_high = wdat[CPSR_BIT_BANK_HIGH];
          st_nxt.bank_select_low = wdat[CPSR_BIT_BANK_LOW];
          st_nxt.signed_wrap_flag = wdat[CPSR_BIT_SIGNED_WRAP];
          st_nxt.user_flag_one = wdat[CPSR_BIT_USER_ONE];
        end
        default: begin
        end
      endcase
    end
    if (push_i) begin
      st_nxt.stack_top_pointer = st_r.stack_top_pointer + 8'h01;
      st_nxt.stack_wr = 1'b1;
      st_nxt.stack_wr_addr = st_r.stack_top_pointer + 8'h01;
      st_nxt.stack_wr_data = push_data_i;
    end else if (pop_i) begin
      st_nxt.stack_top_pointer = st_r.stack_top_pointer - 8'h01;
    end
    if (data_pointer_pair_load_i) begin
      {st_nxt.data_pointer_high, st_nxt.data_pointer_low} = data_pointer_pair_load_val_i;
    end else if (data_pointer_pair_inc_i) begin
      {st_nxt.data_pointer_high, st_nxt.data_pointer_low} = data_pointer_pair_next;
    end
    if (fu_update) begin
      st_nxt.carry_flag = fu_flags.carry;
      st_nxt.half_carry_flag = fu_flags.half_carry;
      st_nxt.signed_wrap_flag = fu_flags.signed_wrap;
    end
    st_nxt.rdata = 32'h0000_0000;
    if (bus_rd) begin
      case (idx)
        CPSR_IDX_STACK_TOP_POINTER: begin
          st_nxt.rdata = {24'h00_0000, st_r.stack_top_pointer};
        end
        CPSR_IDX_DATA_POINTER_LOW: begin
          st_nxt.rdata = {24'h00_0000, st_r.data_pointer_low};
        end
        CPSR_IDX_DATA_POINTER_HIGH: begin
          st_nxt.rdata = {24'h00_0000, st_r.data_pointer_high};
        end
        CPSR_IDX_PROGRAM_STATUS_WORD: begin
          st_nxt.rdata = {24'h00_0000, psw_now};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.stack_top_pointer <= CPSR_RST_STACK_TOP_POINTER;
      st_r.data_pointer_low <= CPSR_RST_DATA_POINTER_LOW;
      st_r.data_pointer_high <= CPSR_RST_DATA_POINTER_HIGH;
      {st_r.carry_flag, st_r.half_carry_flag, st_r.user_flag_zero, st_r.bank_select_high,
       st_r.bank_select_low, st_r.signed_wrap_flag, st_r.user_flag_one} <= CPSR_RST_PROGRAM_STATUS_WORD[7:1];
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_dat_o = st_r.rdata;
  assign stack_wr_o = st_r.stack_wr;
  assign stack_wr_addr_o = st_r.stack_wr_addr;
  assign stack_wr_data_o = st_r.stack_wr_data;
  assign pop_addr_o = st_r.stack_top_pointer;
  assign data_pointer_pair_o = {st_r.data_pointer_high, st_r.data_pointer_low};
  assign bank_select_o = {st_r.bank_select_high, st_r.bank_select_low};
  assign work_reg_addr_o = bank_addr(bank_select_o, work_reg_i);
  assign program_status_word_o = psw_now;
endmodule // cpsr_regs
`default_nettype wire

// ---- rtl/cpsr_pkg.sv ----
// Purpose: constants and types shared by the pointer and status register block
// Assumes: 8-bit special function registers on a 32-bit classic Wishbone slave
// Notes: register index times four gives the byte address
package cpsr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CPSR_IDX_STACK_TOP_POINTER = 8'h81;
  localparam logic [7:0] CPSR_IDX_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] CPSR_IDX_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] CPSR_IDX_PROGRAM_STATUS_WORD = 8'hD0;
  localparam int CPSR_ADDR_W = 10;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CPSR_RST_STACK_TOP_POINTER = 8'h07;
  localparam logic [7:0] CPSR_RST_DATA_POINTER_LOW = 8'h00;
  localparam logic [7:0] CPSR_RST_DATA_POINTER_HIGH = 8'h00;
  localparam logic [7:0] CPSR_RST_PROGRAM_STATUS_WORD = 8'h00;

  // ****************************************
  // status word fields
  // ****************************************
  localparam int CPSR_BIT_CARRY = 7;
  localparam int CPSR_BIT_HALF_CARRY = 6;
  localparam int CPSR_BIT_USER_ZERO = 5;
  localparam int CPSR_BIT_BANK_HIGH = 4;
  localparam int CPSR_BIT_BANK_LOW = 3;
  localparam int CPSR_BIT_SIGNED_WRAP = 2;
  localparam int CPSR_BIT_USER_ONE = 1;
  localparam int CPSR_BIT_PARITY = 0;
  localparam logic [7:0] CPSR_BCD_LIMIT = 8'h99;
  localparam logic [15:0] CPSR_BYTE_MAX = 16'h00FF;

  // ****************************************
  // flag operations from the datapath
  // ****************************************
  typedef enum logic [3:0] {
    CPSR_OP_NONE,
    CPSR_OP_ADD,
    CPSR_OP_ADDC,
    CPSR_OP_SUBB,
    CPSR_OP_MUL,
    CPSR_OP_DIV,
    CPSR_OP_DA,
    CPSR_OP_CJNE,
    CPSR_OP_SET_CARRY
  } cpsr_op_t;

  typedef struct packed {
    logic carry;
    logic half_carry;
    logic signed_wrap;
  } cpsr_flags_t;
endpackage

// ---- rtl/cpsr_flag_unit.sv ----
// Purpose: arithmetic flag results for one datapath operation
// Assumes: operands are the values before the operation
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module cpsr_flag_unit
  import cpsr_pkg::*;
(
  // operation
  input wire cpsr_op_t op_i,
  input wire logic [7:0] opa_i,
  input wire logic [7:0] opb_i,
  input wire logic carry_in_i,
  input wire logic half_in_i,
  input wire logic wrap_in_i,
  input wire logic [15:0] product_i,
  input wire logic divisor_zero_i,
  // results
  output logic update_o,
  output var cpsr_flags_t flags_o
);
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum7;
  logic [8:0] dif9;
  logic [4:0] dif5;
  logic [7:0] dif7;
  logic cin;
  logic [8:0] da_adj;

  always_comb begin
    cin = (op_i == CPSR_OP_ADDC) ? carry_in_i : 1'b0;
    sum9 = {1'b0, opa_i} + {1'b0, opb_i} + {8'h00, cin};
    sum5 = {1'b0, opa_i[3:0]} + {1'b0, opb_i[3:0]} + {4'h0, cin};
    sum7 = {1'b0, opa_i[6:0]} + {1'b0, opb_i[6:0]} + {7'h00, cin};
    dif9 = {1'b0, opa_i} - {1'b0, opb_i} - {8'h00, carry_in_i};
    dif5 = {1'b0, opa_i[3:0]} - {1'b0, opb_i[3:0]} - {4'h0, carry_in_i};
    dif7 = {1'b0, opa_i[6:0]} - {1'b0, opb_i[6:0]} - {7'h00, carry_in_i};
    da_adj = {1'b0, opa_i};
    if (half_in_i || (opa_i[3:0] > 4'h9)) begin
      da_adj = da_adj + 9'h006;
    end
    update_o = 1'b1;
    flags_o = '{carry: carry_in_i, half_carry: half_in_i, signed_wrap: wrap_in_i};
    case (op_i)
      CPSR_OP_ADD, CPSR_OP_ADDC: begin
        flags_o.carry = sum9[8];
        flags_o.half_carry = sum5[4];
        flags_o.signed_wrap = sum9[8] ^ sum7[7];
      end
      CPSR_OP_SUBB: begin
        flags_o.carry = dif9[8];
        flags_o.half_carry = dif5[4];
        flags_o.signed_wrap = dif9[8] ^ dif7[7];
      end
      CPSR_OP_MUL: begin
        flags_o.carry = 1'b0;
        flags_o.signed_wrap = product_i > CPSR_BYTE_MAX;
      end
      CPSR_OP_DIV: begin
        flags_o.carry = 1'b0;
        flags_o.signed_wrap = divisor_zero_i;
      end
      CPSR_OP_DA: begin
        // carry only ever sets here, a carry from the add is kept
        flags_o.carry = carry_in_i || da_adj[8] || (da_adj[7:0] > CPSR_BCD_LIMIT);
      end
      CPSR_OP_CJNE: begin
        flags_o.carry = opa_i < opb_i;
      end
      CPSR_OP_SET_CARRY: begin
        flags_o.carry = carry_in_i;
      end
      default: begin
        update_o = 1'b0;
      end
    endcase
  end
endmodule // cpsr_flag_unit
`default_nettype wire

// ---- rtl/cpsr_wb_slave.sv ----
// Purpose: classic Wishbone handshake for the register block
// Assumes: single cycle requests, master holds until ack
// Notes: ack one cycle after the strobe, dropped the next cycle
`timescale 1ns/1ps
`default_nettype none
module cpsr_wb_slave
  import cpsr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus side
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic sel0_i,
  // access strobes
  output logic wr_o,
  output logic rd_o,
  output logic ack_o
);
  typedef struct packed {
    logic ack;
  } cpsr_wbs_state_t;

  cpsr_wbs_state_t st_r;
  cpsr_wbs_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = cyc_i && stb_i && !st_r.ack;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // write takes effect on the edge that the master samples ack
  assign wr_o = st_r.ack && cyc_i && stb_i && we_i && sel0_i;
  assign rd_o = cyc_i && stb_i && !we_i && !st_r.ack;
  assign ack_o = st_r.ack;
endmodule // cpsr_wb_slave
`default_nettype wire

// ---- tb/cpsr_regs_monitor.sv ----
// Purpose: assertion checker for cpsr_regs
// Assumes: one clock, synchronous reset
// Notes: attached to every cpsr_regs by bind
`timescale 1ns/1ps
`default_nettype none
module cpsr_regs_monitor
  import cpsr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // stack
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [7:0] push_data_i,
  input wire logic stack_wr_o,
  input wire logic [7:0] stack_wr_addr_o,
  input wire logic [7:0] stack_wr_data_o,
  input wire logic [7:0] pop_addr_o,
  // data pointer
  input wire logic data_pointer_pair_load_i,
  input wire logic data_pointer_pair_inc_i,
  input wire logic [15:0] data_pointer_pair_load_val_i,
  input wire logic [15:0] data_pointer_pair_o,
  // flags and banks
  input wire cpsr_op_t flag_op_i,
  input wire logic [7:0] opa_i,
  input wire logic [7:0] opb_i,
  input wire logic [15:0] product_i,
  input wire logic [7:0] accumulator_i,
  input wire logic [2:0] work_reg_i,
  input wire logic [7:0] work_reg_addr_o,
  input wire logic [1:0] bank_select_o,
  input wire logic [7:0] program_status_word_o
);
  logic [7:0] ps;
  logic [8:0] sum_w;
  logic ov_w;
  logic ac_w;
  // reference add flags, independent of the design
  assign ps = program_status_word_o;
  assign sum_w = {1'b0, opa_i} + {1'b0, opb_i};
  assign ov_w = (opa_i[7] == opb_i[7]) && (sum_w[7] != opa_i[7]);
  assign ac_w = ({1'b0, opa_i[3:0]} + {1'b0, opb_i[3:0]}) > 5'h0F;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // properties
  // ****************************************
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_store; stack_wr_o && stack_wr_addr_o == pop_addr_o && stack_wr_data_o == $past(push_data_i); endsequence
  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_push; push_i |=> s_store and (pop_addr_o == $past(pop_addr_o) + 8'h01); endproperty
  a_push: assert property (p_push) else $error("push store wrong");
  property p_pop; pop_i && !push_i |=> pop_addr_o == $past(pop_addr_o) - 8'h01; endproperty
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  property p_rst; $fell(rst_i) |-> pop_addr_o == 8'h07 && data_pointer_pair_o == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_dload; data_pointer_pair_load_i |=> data_pointer_pair_o == $past(data_pointer_pair_load_val_i); endproperty
  a_dload: assert property (p_dload) else $error("pointer load wrong");
  property p_dinc; data_pointer_pair_inc_i && !data_pointer_pair_load_i |=> data_pointer_pair_o == $past(data_pointer_pair_o) + 16'h0001; endproperty
  a_dinc: assert property (p_dinc) else $error("pointer increment wrong");
  property p_add; flag_op_i == CPSR_OP_ADD |=> {ps[7], ps[6], ps[2]} == {$past(sum_w[8]), $past(ac_w), $past(ov_w)}; endproperty
  a_add: assert property (p_add) else $error("add flags wrong");
  property p_mdc; flag_op_i inside {CPSR_OP_MUL, CPSR_OP_DIV} |=> !ps[7]; endproperty
  a_mdc: assert property (p_mdc) else $error("carry not cleared");
  property p_mov; flag_op_i == CPSR_OP_MUL |=> ps[2] == ($past(product_i) > 16'h00FF); endproperty
  a_mov: assert property (p_mov) else $error("multiply overflow wrong");
  property p_da; flag_op_i == CPSR_OP_DA && ps[7] |=> ps[7]; endproperty
  a_da: assert property (p_da) else $error("adjust lost carry");
  property p_cmp; flag_op_i == CPSR_OP_CJNE |=> ps[7] == ($past(opa_i) < $past(opb_i)); endproperty
  a_cmp: assert property (p_cmp) else $error("compare carry wrong");
  property p_par; ps[0] == ^accumulator_i; endproperty
  a_par: assert property (p_par) else $error("parity wrong");
  property p_bank; work_reg_addr_o == {3'b000, ps[4:3], work_reg_i} && bank_select_o == ps[4:3]; endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");
endmodule // cpsr_regs_monitor
bind cpsr_regs cpsr_regs_monitor u_mon (.*);
`default_nettype wire

// ---- tb/cpsr_regs_tb_top.sv ----
// Purpose: self-checking bench for cpsr_regs
// Assumes: classic single-cycle bus, 50 MHz clock
// Notes: flag cases in a table, the rest by hand
`timescale 1ns/1ps
`default_nettype none
module cpsr_regs_tb_top
  import cpsr_pkg::*;
;
  typedef struct packed {cpsr_op_t op; logic [7:0] a; logic [7:0] b; logic [15:0] p; logic dz; logic [2:0] m;
    logic [2:0] e;} cpsr_row_t;
  // e and m are {carry, half carry, overflow}; rows chain the carry
  localparam cpsr_row_t ROWS [14] = '{'{CPSR_OP_ADD, 8'h80, 8'h80, 16'h0000, 1'b0, 3'h7, 3'h5},
    '{CPSR_OP_ADDC, 8'h0F, 8'h00, 16'h0000, 1'b0, 3'h7, 3'h2}, '{CPSR_OP_SUBB, 8'h00, 8'h01, 16'h0000, 1'b0, 3'h7, 3'h6},
    '{CPSR_OP_SUBB, 8'h80, 8'h00, 16'h0000, 1'b0, 3'h7, 3'h3}, '{CPSR_OP_MUL, 8'h00, 8'h00, 16'h0100, 1'b0, 3'h5, 3'h1},
    '{CPSR_OP_MUL, 8'h00, 8'h00, 16'h00FF, 1'b0, 3'h5, 3'h0}, '{CPSR_OP_DIV, 8'h00, 8'h00, 16'h0000, 1'b1, 3'h5, 3'h1},
    '{CPSR_OP_SET_CARRY, 8'h00, 8'h01, 16'h0000, 1'b0, 3'h4, 3'h4},
    '{CPSR_OP_CJNE, 8'h02, 8'h01, 16'h0000, 1'b0, 3'h4, 3'h0},
    '{CPSR_OP_DA, 8'h00, 8'h00, 16'h0000, 1'b0, 3'h4, 3'h0}, '{CPSR_OP_DA, 8'h9A, 8'h00, 16'h0000, 1'b0, 3'h4, 3'h4},
    '{CPSR_OP_DA, 8'h00, 8'h00, 16'h0000, 1'b0, 3'h4, 3'h4},
    '{CPSR_OP_SET_CARRY, 8'h00, 8'h00, 16'h0000, 1'b0, 3'h4, 3'h0},
    '{CPSR_OP_CJNE, 8'h01, 8'h02, 16'h0000, 1'b0, 3'h4, 3'h4}};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, push_i, pop_i, stack_wr_o, data_pointer_pair_load_i, data_pointer_pair_inc_i;
  logic divisor_zero_i, carry_set_i;
  logic [3:0] wb_sel_i, sel_v;
  logic [CPSR_ADDR_W-1:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] push_data_i, stack_wr_addr_o, stack_wr_data_o, pop_addr_o, opa_i, opb_i, accumulator_i, work_reg_addr_o;
  logic [7:0] program_status_word_o, q;
  logic [15:0] data_pointer_pair_load_val_i, data_pointer_pair_o, product_i;
  logic [2:0] work_reg_i;
  logic [1:0] bank_select_o;
  cpsr_op_t flag_op_i;
  int error_cnt, compares;
  cpsr_regs u_dut (.*);
  always #10 clk_i = ~clk_i;
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // holds the request until ack is sampled, then releases
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_v;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      stop_test();
    end else begin
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, push_i, pop_i, data_pointer_pair_load_i, data_pointer_pair_inc_i} = 9'h001 << 7;
    {divisor_zero_i, carry_set_i, wb_adr_i, wb_dat_i, push_data_i, opa_i, opb_i, accumulator_i} = '0;
    {data_pointer_pair_load_val_i, product_i, work_reg_i} = '0;
    wb_sel_i = 4'hF;
    sel_v = 4'hF;
    flag_op_i = CPSR_OP_NONE;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CPSR_IDX_STACK_TOP_POINTER, 8'h00);
    chk("sp reset", 16'h0007, 16'(q));
    foreach (ROWS[i]) begin
      @(posedge clk_i);
      flag_op_i <= ROWS[i].op;
      opa_i <= ROWS[i].a;
      opb_i <= ROWS[i].b;
      product_i <= ROWS[i].p;
      divisor_zero_i <= ROWS[i].dz;
      carry_set_i <= ROWS[i].b[0];
      @(posedge clk_i);
      flag_op_i <= CPSR_OP_NONE;
      @(posedge clk_i);
      chk("flags", 16'(ROWS[i].e), 16'({program_status_word_o[7:6], program_status_word_o[2]} & ROWS[i].m));
    end
    $display("done: flag table");
    @(posedge clk_i);
    push_i <= 1'b1;
    push_data_i <= 8'hA5;
    @(posedge clk_i);
    push_data_i <= 8'h5A;
    @(posedge clk_i);
    push_i <= 1'b0;
    chk("push1", 16'hA508, {stack_wr_data_o, stack_wr_addr_o});
    @(posedge clk_i);
    chk("push2", 16'h5A09, {stack_wr_data_o, stack_wr_addr_o});
    pop_i <= 1'b1;
    @(posedge clk_i);
    pop_i <= 1'b0;
    @(posedge clk_i);
    chk("pop", 16'h0008, 16'(pop_addr_o));
    push_i <= 1'b1;
    pop_i <= 1'b1;
    @(posedge clk_i);
    {push_i, pop_i} <= 2'b00;
    @(posedge clk_i);
    chk("push over pop", 16'h0909, {pop_addr_o, stack_wr_addr_o});
    $display("done: push");
    wb(1'b1, CPSR_IDX_DATA_POINTER_LOW, 8'hFF);
    wb(1'b1, CPSR_IDX_DATA_POINTER_HIGH, 8'h12);
    @(posedge clk_i);
    data_pointer_pair_inc_i <= 1'b1;
    @(posedge clk_i);
    data_pointer_pair_inc_i <= 1'b0;
    @(posedge clk_i);
    chk("data_pointer_pair", 16'h1300, data_pointer_pair_o);
    wb(1'b0, CPSR_IDX_DATA_POINTER_HIGH, 8'h00);
    chk("dph", 16'h0013, 16'(q));
    data_pointer_pair_load_val_i <= 16'hBEEF;
    data_pointer_pair_load_i <= 1'b1;
    data_pointer_pair_inc_i <= 1'b1;
    @(posedge clk_i);
    {data_pointer_pair_load_i, data_pointer_pair_inc_i} <= 2'b00;
    @(posedge clk_i);
    chk("data_pointer_pair load", 16'hBEEF, data_pointer_pair_o);
    $display("done: pointer");
    work_reg_i <= 3'd5;
    for (int n = 0; n < 4; n++) begin
      wb(1'b1, CPSR_IDX_PROGRAM_STATUS_WORD, {3'b001, 2'(n), 3'b000});
      wb(1'b0, CPSR_IDX_PROGRAM_STATUS_WORD, 8'h00);
      chk("psw", 16'({3'b001, 2'(n), 3'b000}), 16'(q));
      chk("bank", 16'({2'(n), 3'b101}), 16'(work_reg_addr_o));
    end
    $display("done: banks");
    sel_v = 4'hE;
    wb(1'b1, CPSR_IDX_STACK_TOP_POINTER, 8'h33);
    sel_v = 4'hF;
    wb(1'b1, 8'h84, 8'h55);
    wb(1'b0, 8'h84, 8'h00);
    chk("unmapped", 16'h0000, 16'(q));
    wb(1'b0, CPSR_IDX_STACK_TOP_POINTER, 8'h00);
    chk("sel0 low", 16'h0009, 16'(q));
    $display("done: refusals");
    accumulator_i <= 8'h07;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CPSR_IDX_PROGRAM_STATUS_WORD, 8'h00);
    chk("parity", 16'h0001, 16'(q));
    wb(1'b0, CPSR_IDX_STACK_TOP_POINTER, 8'h00);
    chk("sp rereset", 16'h0007, 16'(q));
    $display("done: second reset");
    stop_test();
  end
endmodule // cpsr_regs_tb_top
`default_nettype wire
